/* File: verilog/aeo_port.sv */
/*
  digital side of a pipelined sampling converter: encode clock sampling,
  output formatting, overflow flag and delayed sample strobe clock.
  assumes i_mclk much faster than the encode clock; the quantizer result
  arrives on i_conv_* in the i_mclk domain.
*/
// Contract
// - output word is offset binary when format select high, two's complement when low.
// - overflow flag is high exactly when the sample is out of range.
// - sample strobe clock is a delayed copy of the encode clock.
// - word and flag change only just after the strobe clock falls.
// - each conversion's sampling period begins on the encode clock falling edge.
`timescale 1ns/100ps
`default_nettype none

`include "aeo_defines.svh"

module aeo_port #(
  parameter int PIPE_DEPTH   = `AEO_PIPE_DEPTH,
  parameter int STROBE_DELAY = `AEO_STROBE_DELAY
) (
  input  wire  logic              i_mclk,
  input  wire  logic              i_reset,
  input  wire  logic              i_encode_clock_in,
  input  wire  logic              i_output_format_select,
  input  wire  aeo_pkg::aeo_word_t i_conv_word,
  input  wire  logic              i_conv_over,
  input  wire  logic              i_conv_under,
  output logic                    o_sample_strobe_clock,
  output aeo_pkg::aeo_word_t      o_sample_word,
  output logic                    o_range_overflow_flag,
  output logic                    o_phase_short
);
  import aeo_pkg::*;

  // ==========================================================
  // encode clock synchroniser and edge detect
  logic [1:0] enc_sync_reg;
  logic       enc_prev_reg;
  logic       enc_level;
  logic       enc_fall;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      enc_sync_reg <= 2'h0;
    end else begin
      enc_sync_reg <= {enc_sync_reg[0], i_encode_clock_in};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      enc_prev_reg <= 1'b0;
    end else begin
      enc_prev_reg <= enc_sync_reg[1];
    end
  end

  assign enc_level = enc_sync_reg[1];
  assign enc_fall  = enc_prev_reg & ~enc_level;

  // ==========================================================
  // format select synchroniser
  logic [1:0] fmt_sync_reg;
  logic       fmt_offset;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      fmt_sync_reg <= 2'h0;
    end else begin
      fmt_sync_reg <= {fmt_sync_reg[0], i_output_format_select};
    end
  end

  assign fmt_offset = fmt_sync_reg[1];

  // ==========================================================
  // phase width monitor (flags an encode phase lasting PHASE_MIN i_mclk cycles or fewer)
  localparam logic [7:0] PHASE_CNT_MAX = 8'hff;
  localparam logic [7:0] PHASE_MIN     = 8'(`AEO_MIN_PHASE_CYC);

  aeo_phase_e phase_reg;
  aeo_phase_e phase_next;
  logic [7:0] phase_cnt_reg;
  logic [7:0] phase_cnt_next;
  logic       phase_short_next;
  logic       phase_sat;

  assign phase_sat = (phase_cnt_reg == PHASE_CNT_MAX);

  always_comb begin
    phase_next       = phase_reg;
    phase_short_next = o_phase_short;
    if (phase_sat) begin
      phase_cnt_next = phase_cnt_reg;
    end else begin
      phase_cnt_next = phase_cnt_reg + 8'h01;
    end
    case (phase_reg)
      AEO_ST_LOW: begin
        if (enc_level) begin
          phase_next       = AEO_ST_HIGH;
          phase_cnt_next   = 8'h00;
          phase_short_next = (phase_cnt_reg < PHASE_MIN);
        end
      end
      AEO_ST_HIGH: begin
        if (!enc_level) begin
          phase_next       = AEO_ST_LOW;
          phase_cnt_next   = 8'h00;
          phase_short_next = (phase_cnt_reg < PHASE_MIN);
        end
      end
      default: begin
        phase_next     = AEO_ST_LOW;
        phase_cnt_next = 8'h00;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      phase_reg     <= AEO_ST_LOW;
      phase_cnt_reg <= 8'h00;
    end else begin
      phase_reg     <= phase_next;
      phase_cnt_reg <= phase_cnt_next;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_phase_short <= 1'b0;
    end else begin
      o_phase_short <= phase_short_next;
    end
  end

  // ==========================================================
  // conversion capture on encode falling edge
  aeo_sample_s conv_s;
  aeo_sample_s piped_s;

  always_comb begin
    conv_s.word = i_conv_word;
    conv_s.ovf  = i_conv_over | i_conv_under;
  end

  aeo_pipe #(
    .DEPTH (PIPE_DEPTH)
  ) u_pipe (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_adv   (enc_fall),
    .i_din   (conv_s),
    .o_dout  (piped_s)
  );

  // ==========================================================
  // delayed strobe clock
  logic [STROBE_DELAY-1:0] strobe_dly_reg;
  logic                    strobe_prev_reg;
  logic                    strobe_fall;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      strobe_dly_reg <= '0;
    end else begin
      strobe_dly_reg <= {strobe_dly_reg[STROBE_DELAY-2:0], enc_level};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_sample_strobe_clock <= 1'b0;
    end else begin
      o_sample_strobe_clock <= strobe_dly_reg[STROBE_DELAY-1];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      strobe_prev_reg <= 1'b0;
    end else begin
      strobe_prev_reg <= o_sample_strobe_clock;
    end
  end

  // strobe pin already low here, so the word moves one cycle after its fall
  assign strobe_fall = strobe_prev_reg & ~o_sample_strobe_clock;

  // ==========================================================
  // output word and flag, updated just after strobe falls
  aeo_word_t word_next;
  logic      flag_next;

  always_comb begin
    word_next = o_sample_word;
    flag_next = o_range_overflow_flag;
    if (strobe_fall) begin
      if (fmt_offset) begin
        word_next = piped_s.word ^ `AEO_MSB_FLIP;
      end else begin
        word_next = piped_s.word;
      end
      flag_next = piped_s.ovf;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_sample_word <= '0;
    end else begin
      o_sample_word <= word_next;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_range_overflow_flag <= 1'b0;
    end else begin
      o_range_overflow_flag <= flag_next;
    end
  end
endmodule

`default_nettype wire

/* File: verilog/aeo_defines.svh */
/*
  constants for the encode and output port: widths, pipeline depth, timing counts.
  assumes inclusion by bare name from the package and design files.
*/
`ifndef AEO_DEFINES_SVH
`define AEO_DEFINES_SVH

`define AEO_DATA_W        14
`define AEO_PIPE_DEPTH    3
`define AEO_STROBE_DELAY  2
`define AEO_CLK_PERIOD_NS 10
`define AEO_MIN_PHASE_NS  6
`define AEO_MIN_PHASE_CYC ((`AEO_MIN_PHASE_NS + `AEO_CLK_PERIOD_NS - 1) / `AEO_CLK_PERIOD_NS)
`define AEO_MSB_FLIP      14'h2000

`endif

/* File: verilog/aeo_pkg.sv */
/*
  types for the encode and output port.
  assumes aeo_defines.svh is on the include path.
*/
`include "aeo_defines.svh"

package aeo_pkg;
  typedef logic [`AEO_DATA_W-1:0] aeo_word_t;

  // one conversion result travelling down the pipeline
  typedef struct packed {
    aeo_word_t word;
    logic      ovf;
  } aeo_sample_s;

  typedef enum logic [1:0] {
    AEO_ST_LOW,
    AEO_ST_HIGH
  } aeo_phase_e;
endpackage

/* File: verilog/aeo_pipe.sv */
/*
  pipeline stage chain carrying conversion results.
  assumes a single clock; shift only on the given advance pulse.
*/
`timescale 1ns/100ps
`default_nettype none

module aeo_pipe #(
  parameter int DEPTH = 3
) (
  input  wire  logic                i_mclk,
  input  wire  logic                i_reset,
  input  wire  logic                i_adv,
  input  wire  aeo_pkg::aeo_sample_s i_din,
  output var   aeo_pkg::aeo_sample_s o_dout
);
  import aeo_pkg::*;

  aeo_sample_s stage_reg [DEPTH];

  // ==========================================================
  // shift chain
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      for (int k = 0; k < DEPTH; k++) begin
        stage_reg[k] <= '0;
      end
    end else if (i_adv) begin
      stage_reg[0] <= i_din;
      for (int k = 1; k < DEPTH; k++) begin
        stage_reg[k] <= stage_reg[k-1];
      end
    end
  end

  assign o_dout = stage_reg[DEPTH-1];
endmodule

`default_nettype wire

/* File: dv/aeo_port_asserts.sv */
/* checker for aeo_port output timing.
   assumes the bind below; sees only the port's pins. */
`timescale 1ns/100ps
`default_nettype none
// ====
// checks
module aeo_port_asserts (
  input wire logic               i_mclk,
  input wire logic               i_reset,
  input wire logic               i_encode_clock_in,
  input wire logic               o_sample_strobe_clock,
  input wire aeo_pkg::aeo_word_t o_sample_word,
  input wire logic               o_range_overflow_flag
);
  import aeo_pkg::*;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  sequence drop_s;
    $fell(o_sample_strobe_clock);
  endsequence
  rise_follow_a: assert property ($rose(i_encode_clock_in) |-> ##[3:7] $rose(o_sample_strobe_clock))
    else $error("strobe missed rise");
  fall_follow_a: assert property ($fell(i_encode_clock_in) |-> ##[3:7] drop_s)
    else $error("strobe missed fall");
  strobe_hold_a: assert property (drop_s |=> !o_sample_strobe_clock [*2])
    else $error("strobe low too short");
  word_timing_a: assert property ($changed(o_sample_word) |-> !$past(o_sample_strobe_clock) && $past(o_sample_strobe_clock, 2))
    else $error("word moved off strobe fall");
  flag_timing_a: assert property ($changed(o_range_overflow_flag) |-> !$past(o_sample_strobe_clock) && $past(o_sample_strobe_clock, 2))
    else $error("flag moved off strobe fall");
  word_hold_a: assert property (drop_s |=> ##1 $stable(o_sample_word) [*4])
    else $error("word not held");
endmodule
bind aeo_port aeo_port_asserts u_asserts (.i_mclk, .i_reset, .i_encode_clock_in, .o_sample_strobe_clock,
  .o_sample_word, .o_range_overflow_flag);
`default_nettype wire

/* File: dv/aeo_capture_model.sv */
/* capture logic model: latches word and flag.
   assumes strobe, word and flag straight from aeo_port. */
`timescale 1ns/100ps
`default_nettype none
// ====
// capture
module aeo_capture_model (
  input  wire logic                 i_strobe,
  input  wire aeo_pkg::aeo_word_t   i_word,
  input  wire logic                 i_flag,
  output var  aeo_pkg::aeo_sample_s o_cap,
  output var  int                   o_count
);
  import aeo_pkg::*;
  int cnt = 0;
  assign o_count = cnt;
  always @(posedge i_strobe) begin
    o_cap <= {i_word, i_flag};
    cnt <= cnt + 1;
  end
endmodule
`default_nettype wire

/* File: dv/adc_encode_and_output_port_bench.sv */
/* bench for aeo_port: random and corner samples, checked at the capture model.
   assumes design, package, checker and model compiled first. */
`timescale 1ns/100ps
`default_nettype none
// ====
// bench
module adc_encode_and_output_port_bench;
  import aeo_pkg::*;
  logic mclk = 0, rst = 1, encode_clock_in = 0, sel = 0, over = 0, under = 0, strobe, ovf, phs_short;
  aeo_word_t word = '0, q;
  aeo_sample_s cap;
  int count, fail_count = 0, num_checks = 0, cyc = 0;
  logic [15:0] smp [64];
  logic fmt [64];
  logic [15:0] corner [4] = '{16'h9fff, 16'h6000, 16'h0000, 16'h3fff};
  initial forever #5 mclk = ~mclk;
  aeo_port u_dut (.i_mclk(mclk), .i_reset(rst), .i_encode_clock_in(encode_clock_in), .i_output_format_select(sel),
    .i_conv_word(word), .i_conv_over(over), .i_conv_under(under), .o_sample_strobe_clock(strobe),
    .o_sample_word(q), .o_range_overflow_flag(ovf), .o_phase_short(phs_short));
  aeo_capture_model u_cap (.i_strobe(strobe), .i_word(q), .i_flag(ovf), .o_cap(cap), .o_count(count));
  function automatic logic [15:0] exp_of(logic [15:0] s, logic f);
    return {1'b0, s[13:0] ^ {f, 13'h0000}, s[15] | s[14]};
  endfunction
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(93));
    repeat (5) @(negedge mclk);
    rst = 0;
    for (int n = 0; n < 48; n++) begin
      smp[n] = n < 4 ? corner[n] : 16'($urandom);
      if (smp[n][15])
        smp[n][14] = 1'b0;
      fmt[n] = 1'($urandom);
      @(negedge mclk);
      {over, under, word} = smp[n];
      sel = fmt[n];
      encode_clock_in = 1;
      repeat (8) @(negedge mclk);
      if (n > 2)
        check("sample", {1'b0, cap}, exp_of(smp[n-3], fmt[n-1]));
      check("strobes", count[15:0], 16'(n + 1));
      check("phase short", {15'h0000, phs_short}, 16'h0000);
      encode_clock_in = 0;
      repeat (7) @(negedge mclk);
    end
    $display("test samples done");
    @(negedge mclk);
    encode_clock_in = 1;
    @(negedge mclk);
    encode_clock_in = 0;
    repeat (8) @(negedge mclk);
    check("phase short", {15'h0000, phs_short}, 16'h0001);
    check("short strobe", count[15:0], 16'h0031);
    $display("test short phase done");
    print_verdict();
  end
endmodule
`default_nettype wire
